//--- hdl/i2c_bus_node.sv
/*
 * Two-wire bus slave node: open-drain line drive, framing detection,
 * addressed byte receive and transmit, with clock stretching on transmit only.
 * Assumes external pull-ups resolve the wired-AND lines from the enables,
 * and that i_clk_link oversamples the bus clock by a wide margin.
 */
`timescale 1ns/1ns
`default_nettype none

`include "i2c_line_map.svh"

// Operation
// - Nodes only pull lines low or release
// - Bus free only when both lines high
// - Data changes only while clock low
// - Start and stop are data edges, clock high
// - Respond only to own unique address
// - Read: receive address, transmit data, receive acknowledge
// - Transmitter backs off on lost arbitration
// - Operate at one of four rate modes
// - Keep clock edges clean, filter spikes
module i2c_bus_node import i2c_line_pkg::*; #(
    parameter logic [`ADDR_W-1:0] NODE_ADDR = `NODE_ADDR_DEFAULT,
    parameter speed_mode_t SPEED_MODE = MODE_FAST
) (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic i_clk_link,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_scl_o,
    output logic o_scl_oe,
    output logic o_sda_o,
    output logic o_sda_oe,
    output logic o_rx_valid,
    output logic [7:0] o_rx_data,
    output logic o_tx_req,
    output logic o_tx_ready,
    input wire logic i_tx_valid,
    input wire logic [7:0] i_tx_data,
    output logic o_bus_free
);

    // ------------------------------------------------------------------------
    // Rate mode and filter depth
    // ------------------------------------------------------------------------
    // High speed needs a shorter spike window or real bits would be eaten
    localparam int FILT_CYCLES = (SPEED_MODE == MODE_HS) ? `SPIKE_HS_CYCLES : `SPIKE_STD_CYCLES;
    localparam int RATE_KBPS = (SPEED_MODE == MODE_STD) ? `RATE_STD_KBPS :
                               (SPEED_MODE == MODE_FAST) ? `RATE_FAST_KBPS :
                               (SPEED_MODE == MODE_FASTP) ? `RATE_FASTP_KBPS : `RATE_HS_KBPS;

    // ------------------------------------------------------------------------
    // Link domain reset and line conditioning
    // ------------------------------------------------------------------------
    logic rst_link_meta_r;
    logic rst_link_r;
    logic scl_f;
    logic sda_f;
    logic scl_f_r;
    logic sda_f_r;

    always_ff @(posedge i_clk_link) begin
        rst_link_meta_r <= i_srst;
        rst_link_r <= rst_link_meta_r;
    end

    i2c_line_filter #(.STABLE_CYCLES(FILT_CYCLES)) u_scl_filt (
        .i_clk(i_clk_link),
        .i_rst(rst_link_r),
        .i_line(i_scl),
        .o_level(scl_f)
    );

    i2c_line_filter #(.STABLE_CYCLES(FILT_CYCLES)) u_sda_filt (
        .i_clk(i_clk_link),
        .i_rst(rst_link_r),
        .i_line(i_sda),
        .o_level(sda_f)
    );

    always_ff @(posedge i_clk_link) begin
        if (rst_link_r) begin
            scl_f_r <= 1'b1;
            sda_f_r <= 1'b1;
        end else begin
            scl_f_r <= scl_f;
            sda_f_r <= sda_f;
        end
    end

    bus_evt_t ev;
    assign ev.start = scl_f && scl_f_r && sda_f_r && !sda_f;
    assign ev.stop = scl_f && scl_f_r && !sda_f_r && sda_f;
    assign ev.scl_rise = !scl_f_r && scl_f;
    assign ev.scl_fall = scl_f_r && !scl_f;

    // ------------------------------------------------------------------------
    // Link domain state
    // ------------------------------------------------------------------------
    node_state_t state_r, state_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] shift_r, shift_nxt;
    logic [7:0] rx_byte_r, rx_byte_nxt;
    logic rw_r, rw_nxt;
    logic nack_r, nack_nxt;
    logic sda_drv_r, sda_drv_nxt;
    logic scl_drv_r, scl_drv_nxt;
    logic rx_tgl_r, rx_tgl_nxt;
    logic req_tgl_r, req_tgl_nxt;
    logic frame_r, frame_nxt;
    logic bus_free_r;
    logic ack_meta_r, ack_s2_r, ack_s3_r;
    logic [7:0] tx_data_r;
    logic ack_tgl_r;

    wire ack_evt = ack_s2_r ^ ack_s3_r;
    wire addr_hit = (shift_r[7:1] == NODE_ADDR);
    wire byte_done = (cnt_r == `BYTE_BITS);

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        shift_nxt = shift_r;
        rx_byte_nxt = rx_byte_r;
        rw_nxt = rw_r;
        nack_nxt = nack_r;
        sda_drv_nxt = sda_drv_r;
        scl_drv_nxt = scl_drv_r;
        rx_tgl_nxt = rx_tgl_r;
        req_tgl_nxt = req_tgl_r;
        if (ev.stop) begin
            state_nxt = ST_IDLE;
            sda_drv_nxt = 1'b0;
            scl_drv_nxt = 1'b0;
        end else if (ev.start) begin
            state_nxt = ST_ADDR;
            cnt_nxt = 4'h0;
            sda_drv_nxt = 1'b0;
            scl_drv_nxt = 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    state_nxt = ST_IDLE;
                end
                ST_ADDR, ST_RX: begin
                    if (ev.scl_rise) begin
                        shift_nxt = {shift_r[6:0], sda_f};
                        cnt_nxt = cnt_r + 4'h1;
                    end else if (ev.scl_fall && byte_done) begin
                        cnt_nxt = 4'h0;
                        if (state_r == ST_RX) begin
                            state_nxt = ST_ACK_RX;
                            sda_drv_nxt = 1'b1;
                            rx_byte_nxt = shift_r;
                            rx_tgl_nxt = !rx_tgl_r;
                        end else if (addr_hit) begin
                            state_nxt = ST_ACK_ADDR;
                            sda_drv_nxt = 1'b1;
                            rw_nxt = shift_r[0];
                        end else begin
                            state_nxt = ST_IDLE;
                        end
                    end
                end
                ST_ACK_ADDR: begin
                    if (ev.scl_fall) begin
                        sda_drv_nxt = 1'b0;
                        state_nxt = rw_r ? ST_FETCH : ST_RX;
                        scl_drv_nxt = rw_r;
                        req_tgl_nxt = rw_r ? !req_tgl_r : req_tgl_r;
                    end
                end
                ST_ACK_RX: begin
                    if (ev.scl_fall) begin
                        sda_drv_nxt = 1'b0;
                        state_nxt = ST_RX;
                    end
                end
                ST_FETCH: begin
                    // Clock held low until the user side has supplied a byte
                    if (ack_evt) begin
                        shift_nxt = tx_data_r;
                        sda_drv_nxt = !tx_data_r[7];
                        scl_drv_nxt = 1'b0;
                        cnt_nxt = 4'h0;
                        state_nxt = ST_TX;
                    end
                end
                ST_TX: begin
                    if (ev.scl_rise) begin
                        if (!sda_drv_r && !sda_f) begin
                            state_nxt = ST_IDLE;
                        end else begin
                            cnt_nxt = cnt_r + 4'h1;
                        end
                    end else if (ev.scl_fall) begin
                        if (byte_done) begin
                            sda_drv_nxt = 1'b0;
                            state_nxt = ST_WAIT_ACK;
                        end else begin
                            shift_nxt = {shift_r[6:0], 1'b0};
                            sda_drv_nxt = !shift_r[6];
                        end
                    end
                end
                ST_WAIT_ACK: begin
                    if (ev.scl_rise) begin
                        nack_nxt = sda_f;
                    end else if (ev.scl_fall) begin
                        state_nxt = nack_r ? ST_IDLE : ST_FETCH;
                        scl_drv_nxt = !nack_r;
                        req_tgl_nxt = nack_r ? req_tgl_r : !req_tgl_r;
                    end
                end
                default: begin
                    state_nxt = ST_IDLE;
                    sda_drv_nxt = 1'b0;
                    scl_drv_nxt = 1'b0;
                end
            endcase
        end
    end

    assign frame_nxt = ev.start ? 1'b1 : (ev.stop ? 1'b0 : frame_r);

    always_ff @(posedge i_clk_link) begin
        if (rst_link_r) begin
            state_r <= ST_IDLE;
            cnt_r <= 4'h0;
            shift_r <= 8'h00;
            rx_byte_r <= 8'h00;
            rw_r <= 1'b0;
            nack_r <= 1'b0;
            sda_drv_r <= 1'b0;
            scl_drv_r <= 1'b0;
            rx_tgl_r <= 1'b0;
            req_tgl_r <= 1'b0;
            frame_r <= 1'b0;
            bus_free_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            shift_r <= shift_nxt;
            rx_byte_r <= rx_byte_nxt;
            rw_r <= rw_nxt;
            nack_r <= nack_nxt;
            sda_drv_r <= sda_drv_nxt;
            scl_drv_r <= scl_drv_nxt;
            rx_tgl_r <= rx_tgl_nxt;
            req_tgl_r <= req_tgl_nxt;
            frame_r <= frame_nxt;
            bus_free_r <= !frame_nxt && scl_f && sda_f;
        end
    end

    always_ff @(posedge i_clk_link) begin
        ack_meta_r <= ack_tgl_r;
        ack_s2_r <= ack_meta_r;
        ack_s3_r <= ack_s2_r;
    end

    // Pins never drive high; the pull-up makes the high level
    assign o_sda_o = 1'b0;
    assign o_scl_o = 1'b0;
    assign o_sda_oe = sda_drv_r;
    assign o_scl_oe = scl_drv_r;

    // ------------------------------------------------------------------------
    // System domain: crossings and user handshake
    // ------------------------------------------------------------------------
    logic rx_meta_r, rx_s2_r, rx_s3_r;
    logic req_meta_r, req_s2_r, req_s3_r;
    logic free_meta_r;
    logic tx_pend_r;

    wire rx_evt_sys = rx_s2_r ^ rx_s3_r;
    wire tx_take = tx_pend_r && i_tx_valid;

    always_ff @(posedge i_clk_sys) begin
        rx_meta_r <= rx_tgl_r;
        rx_s2_r <= rx_meta_r;
        rx_s3_r <= rx_s2_r;
        req_meta_r <= req_tgl_r;
        req_s2_r <= req_meta_r;
        req_s3_r <= req_s2_r;
        free_meta_r <= bus_free_r;
    end

    // Received byte held stable in the link domain while the toggle crosses
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_rx_valid <= 1'b0;
            o_rx_data <= 8'h00;
            o_bus_free <= 1'b0;
            tx_pend_r <= 1'b0;
            tx_data_r <= 8'h00;
            ack_tgl_r <= 1'b0;
        end else begin
            o_rx_valid <= rx_evt_sys;
            o_rx_data <= rx_evt_sys ? rx_byte_r : o_rx_data;
            o_bus_free <= free_meta_r;
            tx_pend_r <= o_tx_req || (tx_pend_r && !i_tx_valid);
            tx_data_r <= tx_take ? i_tx_data : tx_data_r;
            ack_tgl_r <= tx_take ? !ack_tgl_r : ack_tgl_r;
        end
    end

    assign o_tx_req = req_s2_r ^ req_s3_r;
    assign o_tx_ready = tx_pend_r;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    // Rise-to-rise spacing in link cycles, saturating; slack covers sync jitter
    localparam int BIT_CYC_MIN = (1000000 / RATE_KBPS) / `LINK_CLK_PERIOD_NS - 2;
    localparam int GAP_W = $clog2(BIT_CYC_MIN + 2);
    localparam logic [GAP_W-1:0] GAP_MIN = GAP_W'(BIT_CYC_MIN);
    logic [GAP_W-1:0] rise_gap_r;
    wire gap_full = (rise_gap_r == '1);
    wire [GAP_W-1:0] rise_gap_nxt = ev.scl_rise ? '0 : (gap_full ? rise_gap_r : rise_gap_r + 1'b1);

    // Starts saturated so the first rise after reset is never flagged
    always_ff @(posedge i_clk_link) begin
        if (rst_link_r) begin
            rise_gap_r <= '1;
        end else begin
            rise_gap_r <= rise_gap_nxt;
        end
    end

    sequence s_addr_acked;
        (state_r == ST_ACK_ADDR) ##0 ev.scl_fall;
    endsequence

    sequence s_fetch_wait;
        (state_r == ST_FETCH && scl_drv_r);
    endsequence

    AST_OPEN_DRAIN: assert property (@(posedge i_clk_link) disable iff (rst_link_r)
        (o_sda_oe || o_scl_oe) |-> (!o_sda_o && !o_scl_o && (!o_scl_oe || state_r == ST_FETCH) &&
        (!o_sda_oe || state_r inside {ST_ACK_ADDR, ST_ACK_RX, ST_TX})))
        else $error("line driven to a high level");
    AST_FREE_LINES: assert property (@(posedge i_clk_link) disable iff (rst_link_r)
        bus_free_r |-> ($past(scl_f) && $past(sda_f) && !frame_r))
        else $error("bus reported free while a line was low or a frame open");
    AST_SDA_CLK_LOW: assert property (@(posedge i_clk_link) disable iff (rst_link_r)
        (!$stable(sda_drv_r) && !$past(ev.start) && !$past(ev.stop)) |-> !$past(scl_f))
        else $error("data drive changed while clock high");
    AST_START_ADDR: assert property (@(posedge i_clk_link) disable iff (rst_link_r)
        ev.start |=> (state_r == ST_ADDR && cnt_r == 4'h0 && !sda_drv_r))
        else $error("start not followed by address phase");
    AST_STOP_IDLE: assert property (@(posedge i_clk_link) disable iff (rst_link_r)
        ev.stop |=> (state_r == ST_IDLE && !sda_drv_r && !scl_drv_r) ##1 bus_free_r[*1])
        else $error("stop did not release the lines and free the bus");
    AST_OWN_ADDR: assert property (@(posedge i_clk_link) disable iff (rst_link_r)
        (state_r == ST_ACK_ADDR) |-> (addr_hit && sda_drv_r))
        else $error("acknowledged an address that is not ours");
    AST_READ_ROLE: assert property (@(posedge i_clk_link) disable iff (rst_link_r)
        (s_addr_acked ##0 rw_r) |=> (s_fetch_wait ##0 (req_tgl_r != $past(req_tgl_r))) ##1 s_fetch_wait)
        else $error("read address did not start a held fetch");
    AST_ARB_LOSS: assert property (@(posedge i_clk_link) disable iff (rst_link_r)
        (state_r == ST_TX && ev.scl_rise && !sda_drv_r && !sda_f && !ev.start && !ev.stop)
        |=> (state_r == ST_IDLE) ##1 !sda_drv_r)
        else $error("transmitter kept driving after losing the line");
    AST_RATE_MODE: assert property (@(posedge i_clk_link) disable iff (rst_link_r)
        ev.scl_rise |-> (rise_gap_r >= GAP_MIN))
        else $error("bus clock faster than the selected rate mode");

endmodule // i2c_bus_node

`default_nettype wire

//--- hdl/i2c_line_filter.sv
/*
 * Line conditioner: two-flop synchroniser followed by a stability filter.
 * Assumes i_line is an asynchronous pin level and i_rst is synchronous to i_clk.
 */
`timescale 1ns/1ns
`default_nettype none

module i2c_line_filter #(
    parameter int STABLE_CYCLES = 9
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_line,
    output var logic o_level
);

    localparam int CW = $clog2(STABLE_CYCLES + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(STABLE_CYCLES - 1);

    logic meta_r;
    logic sync_r;
    logic [CW-1:0] cnt_r;
    wire differs = (sync_r != o_level);

    always_ff @(posedge i_clk) begin
        meta_r <= i_line;
        sync_r <= meta_r;
    end

    // Level moves only after the new value has held long enough
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_r <= '0;
            o_level <= 1'b1;
        end else if (!differs) begin
            cnt_r <= '0;
        end else if (cnt_r == CNT_LAST) begin
            cnt_r <= '0;
            o_level <= sync_r;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    AST_FILTER_HOLD: assert property (@(posedge i_clk) disable iff (i_rst)
        !$stable(o_level) |-> ($past(cnt_r) == CNT_LAST))
        else $error("line level moved before the filter time elapsed");

endmodule // i2c_line_filter

`default_nettype wire

//--- include/i2c_line_map.svh
/*
 * Constants of the two-wire bus node: line timing, rate modes and addressing.
 * Assumes the link clock period given here matches the clock on i_clk_link.
 */
`ifndef I2C_LINE_MAP_SVH
`define I2C_LINE_MAP_SVH

// ----------------------------------------------------------------------------
// Link clock and spike suppression
// ----------------------------------------------------------------------------
`define LINK_CLK_PERIOD_NS 6
`define SPIKE_STD_NS 50
`define SPIKE_HS_NS 10
`define SPIKE_STD_CYCLES ((`SPIKE_STD_NS + `LINK_CLK_PERIOD_NS - 1) / `LINK_CLK_PERIOD_NS)
`define SPIKE_HS_CYCLES ((`SPIKE_HS_NS + `LINK_CLK_PERIOD_NS - 1) / `LINK_CLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// Maximum bit rates per mode
// ----------------------------------------------------------------------------
`define RATE_STD_KBPS 100
`define RATE_FAST_KBPS 400
`define RATE_FASTP_KBPS 1000
`define RATE_HS_KBPS 3400

// ----------------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------------
`define ADDR_W 7
`define BYTE_BITS 4'h8
`define NODE_ADDR_DEFAULT 7'h50

`endif

//--- include/i2c_line_pkg.sv
/*
 * Types shared by the bus node and its test bench.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package i2c_line_pkg;

    typedef enum logic [3:0] {
        MODE_STD   = 4'h1,
        MODE_FAST  = 4'h2,
        MODE_FASTP = 4'h4,
        MODE_HS    = 4'h8
    } speed_mode_t;

    typedef enum logic [7:0] {
        ST_IDLE     = 8'h01,
        ST_ADDR     = 8'h02,
        ST_ACK_ADDR = 8'h04,
        ST_RX       = 8'h08,
        ST_ACK_RX   = 8'h10,
        ST_FETCH    = 8'h20,
        ST_TX       = 8'h40,
        ST_WAIT_ACK = 8'h80
    } node_state_t;

    typedef struct packed {
        logic start;
        logic stop;
        logic scl_rise;
        logic scl_fall;
    } bus_evt_t;

endpackage

//--- test/i2c_bus_line_discipline_test.sv
/*
 * Self-checking bench for the bus node: a master model on the wires and a
 * random byte source on the user side.
 * Assumes the design package is compiled before this file.
 */
`timescale 1ns/1ns
`default_nettype none

module i2c_bus_line_discipline_test import i2c_line_pkg::*;;
    localparam logic [6:0] OWN_ADDR = 7'h23;
    logic clk_sys = 1'b0;
    logic clk_link = 1'b0;
    logic srst = 1'b1;
    logic tx_valid = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic scl_oe, sda_oe, scl_o, sda_o, m_scl_oe, m_sda_oe;
    logic rx_valid, tx_req, tx_ready, bus_free;
    logic [7:0] rx_data;
    wire scl;
    wire sda;
    int err_count = 0;
    int cmp_count = 0;
    int req_cnt = 0;
    int seed = 9596;
    logic [7:0] tx_q[$];
    logic [7:0] rx_exp[$];
    logic [7:0] rx_got[$];

    assign scl = ~(m_scl_oe | (scl_oe & ~scl_o));
    assign sda = ~(m_sda_oe | (sda_oe & ~sda_o));

    always #5 clk_sys = ~clk_sys;
    always #3 clk_link = ~clk_link;

    i2c_bus_node #(
        .NODE_ADDR(OWN_ADDR),
        .SPEED_MODE(MODE_FAST)
    ) i2c_bus_node_i (
        .i_clk_sys(clk_sys),
        .i_srst(srst),
        .i_clk_link(clk_link),
        .i_scl(scl),
        .i_sda(sda),
        .o_scl_o(scl_o),
        .o_scl_oe(scl_oe),
        .o_sda_o(sda_o),
        .o_sda_oe(sda_oe),
        .o_rx_valid(rx_valid),
        .o_rx_data(rx_data),
        .o_tx_req(tx_req),
        .o_tx_ready(tx_ready),
        .i_tx_valid(tx_valid),
        .i_tx_data(tx_data),
        .o_bus_free(bus_free)
    );

    i2c_bus_master_model #(
        .QTR_NS(625)
    ) i2c_bus_master_model_i (
        .i_scl(scl),
        .i_sda(sda),
        .o_scl_oe(m_scl_oe),
        .o_sda_oe(m_sda_oe)
    );

    // ------------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------------
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        if (i2c_bus_master_model_i.hang) err_count++;
        if (err_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Wired-AND read; the node goes quiet after its released bit reads low
    function automatic logic [7:0] rd_exp(input logic [7:0] m, input logic [7:0] s);
        logic lost;
        lost = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            rd_exp[i] = lost ? m[i] : (m[i] & s[i]);
            if (s[i] & ~m[i]) lost = 1'b1;
        end
    endfunction

    // ------------------------------------------------------------------
    // Monitors and byte source
    // ------------------------------------------------------------------
    // Falling edge: the pulses launch on the rising one
    always @(negedge clk_sys) begin
        if (rx_valid === 1'b1) rx_got.push_back(rx_data);
        if (tx_req === 1'b1) req_cnt++;
    end

    always @(sda_oe) begin
        if (srst === 1'b0) check("sda_move_clk_high", 8'(scl), 8'h00);
    end

    always @(posedge sda_oe or posedge scl_oe) begin
        check("pull_value", 8'({sda_o, scl_o}), 8'h00);
    end

    always @(negedge clk_sys) begin
        if (tx_ready === 1'b1 && tx_valid === 1'b0) begin
            repeat ($unsigned($random(seed)) % 6) @(negedge clk_sys);
            tx_data <= (tx_q.size() > 0) ? tx_q.pop_front() : 8'h00;
            tx_valid <= 1'b1;
            @(negedge clk_sys);
            tx_valid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Frame tasks
    // ------------------------------------------------------------------
    task automatic wait_free();
        int n;
        n = 0;
        while (bus_free !== 1'b1 && n < 500) begin
            @(negedge clk_sys);
            n++;
        end
        check("bus_free", 8'(bus_free), 8'h01);
        if (n >= 500) stop_test();
    endtask

    task automatic frame(input logic [6:0] a, input logic rd, input int n, input logic [7:0] mpat,
                         input logic [7:0] dor);
        logic [7:0] d, q;
        logic ak, own;
        own = (a == OWN_ADDR);
        i2c_bus_master_model_i.start_cond();
        check("free_in_frame", 8'(bus_free), 8'h00);
        i2c_bus_master_model_i.xfer({a, rd}, q);
        i2c_bus_master_model_i.bit_io(1'b1, ak);
        check("addr_ack", 8'(ak), 8'(!own));
        for (int i = 0; i < n; i++) begin
            d = 8'($random(seed)) | dor;
            if (rd) begin
                if (own) tx_q.push_back(d);
                i2c_bus_master_model_i.xfer(mpat, q);
                check("rd_data", q, rd_exp(mpat, own ? d : 8'hff));
                i2c_bus_master_model_i.bit_io(i == n - 1, ak);
            end else begin
                i2c_bus_master_model_i.xfer(d, q);
                i2c_bus_master_model_i.bit_io(1'b1, ak);
                check("wr_ack", 8'(ak), 8'(!own));
                if (own) rx_exp.push_back(d);
            end
        end
    endtask

    task automatic end_frame();
        i2c_bus_master_model_i.stop_cond();
        wait_free();
        check("rx_count", 8'(rx_got.size()), 8'(rx_exp.size()));
        while (rx_got.size() > 0 && rx_exp.size() > 0) begin
            check("rx_data", rx_got.pop_front(), rx_exp.pop_front());
        end
        rx_got.delete();
        rx_exp.delete();
        if (i2c_bus_master_model_i.hang) stop_test();
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [6:0] a;
        logic dip;
        repeat (10) @(negedge clk_sys);
        check("in_reset", 8'({sda_oe, scl_oe, bus_free, rx_valid, tx_ready}), 8'h00);
        repeat (10) @(negedge clk_sys);
        srst = 1'b0;
        wait_free();
        frame(OWN_ADDR, 1'b0, 3, 8'hff, 8'h00);
        end_frame();
        // One-bit neighbours of the own address, then a random one
        for (int k = 0; k < 3; k++) begin
            a = (k == 0) ? (OWN_ADDR ^ 7'h01) : (OWN_ADDR ^ 7'h40);
            if (k == 2) a = 7'($random(seed));
            if (a == OWN_ADDR) a = a ^ 7'h01;
            frame(a, k[0], 1, 8'hff, 8'h00);
            end_frame();
        end
        frame(OWN_ADDR, 1'b1, 3, 8'hff, 8'h00);
        end_frame();
        // Repeated start turns a write into a read
        frame(OWN_ADDR, 1'b0, 2, 8'hff, 8'h00);
        frame(OWN_ADDR, 1'b1, 2, 8'hff, 8'h00);
        end_frame();
        // Master pulls the first bit that the node leaves high
        frame(OWN_ADDR, 1'b1, 1, 8'h7f, 8'h80);
        end_frame();
        // Spike shorter than the filter must not open a frame
        // A passed spike frames and unframes at once, so watch for any dip
        i2c_bus_master_model_i.spike(20);
        dip = 1'b0;
        repeat (50) begin
            @(negedge clk_sys);
            if (bus_free !== 1'b1) dip = 1'b1;
        end
        check("spike_free", 8'(dip), 8'h00);
        check("spike_rx", 8'(rx_got.size()), 8'h00);
        check("req_count", 8'(req_cnt), 8'h06);
        stop_test();
    end

    initial begin
        #900000;
        err_count++;
        stop_test();
    end
endmodule // i2c_bus_line_discipline_test

`default_nettype wire

//--- test/i2c_bus_master_model.sv
/*
 * Behavioural bus master that drives both open-drain lines through enables.
 * Assumes the bench resolves each line with a pull-up and feeds it back here.
 */
`timescale 1ns/1ns
`default_nettype none

module i2c_bus_master_model #(
    parameter int QTR_NS = 625
) (
    input wire logic i_scl,
    input wire logic i_sda,
    output var logic o_scl_oe,
    output var logic o_sda_oe
);
    logic hang = 1'b0;

    initial begin
        o_scl_oe = 1'b0;
        o_sda_oe = 1'b0;
    end

    // ------------------------------------------------------------------
    // Line primitives
    // ------------------------------------------------------------------
    // Bounded wait: a stuck stretch flags a hang instead of blocking
    task automatic rel_scl();
        int n;
        n = 0;
        o_scl_oe = 1'b0;
        while (i_scl !== 1'b1 && n < 4000) begin
            #50;
            n++;
        end
        if (n >= 4000) hang = 1'b1;
    endtask

    // Four quarters per bit, 400 kbps
    task automatic bit_io(input logic b, output logic r);
        #QTR_NS o_sda_oe = ~b;
        #QTR_NS;
        rel_scl();
        #QTR_NS r = i_sda;
        #QTR_NS o_scl_oe = 1'b1;
    endtask

    task automatic xfer(input logic [7:0] d, output logic [7:0] q);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
            q[i] = r;
        end
    endtask

    // Also serves as repeated start with the clock low
    task automatic start_cond();
        #QTR_NS o_sda_oe = 1'b0;
        #QTR_NS;
        rel_scl();
        #QTR_NS o_sda_oe = 1'b1;
        #QTR_NS o_scl_oe = 1'b1;
    endtask

    task automatic stop_cond();
        #QTR_NS o_sda_oe = 1'b1;
        #QTR_NS;
        rel_scl();
        #QTR_NS o_sda_oe = 1'b0;
        #QTR_NS;
    endtask

    task automatic spike(input int ns);
        o_sda_oe = 1'b1;
        #ns o_sda_oe = 1'b0;
    endtask
endmodule // i2c_bus_master_model

`default_nettype wire
